// File: timer3_pkg.sv
// constants for the reload/capture timer: register indices, field positions,
// prescaler ratios and bus decode positions.
// assumes a 32-bit AHB-Lite slave port, one aligned word per register.
//
// Functional notes
// RULE_01: both mode bits clear gives 16-bit reload timer
// RULE_02: 16-bit rollover loads reload, sets high flag
// RULE_03: 16-bit irq on full overflow, low if enabled
// RULE_04: split mode runs two 8-bit reload timers
// RULE_05: split: run bit gates high byte only
// RULE_06: otherwise run bit starts and stops whole timer
// RULE_07: per-byte select: system clock, else div12 or ext/8
// RULE_08: external divide-by-8 tick synchronised to clk
// RULE_09: low rollover always sets low flag
// RULE_10: split irq on high, either if low enabled
// RULE_11: flags cleared only by software write
// RULE_12: software reads both flags to find source
// RULE_13: source select: zero frame start, one slow-oscillator rise
// RULE_14: capture 16-bit: wrap, copy count, irq
// RULE_15: capture split: two 8-bit counters, copy both
// RULE_16: software keeps low irq enable clear in 16-bit
// RULE_17: control register read-write, resets to zero
// RULE_18: reload bytes hold reload or captured value
// RULE_19: count bytes expose the live count
// RULE_20: capture mode wraps freely without reloading

package timer3_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CONTROL = 8'h91;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h92;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h94;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h95;
  localparam logic [7:0] IDX_CLOCK_SELECT = 8'h96;

  // ==========================================================
  // timer_control_reg fields
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CAP_SRC = 1;
  localparam int BIT_EXT_CLK = 0;

  // clock_select_reg fields
  localparam int BIT_LOW_CLK_SEL = 0;
  localparam int BIT_HIGH_CLK_SEL = 1;
  localparam int BIT_TIMER_IRQ_EN = 2;
  localparam int CLOCK_SELECT_WIDTH = 3;

  // ==========================================================
  // counting and prescaling
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam int SYSTEM_CLOCK_DIV = 12;
  localparam int EXT_DIV = 8;

  // ==========================================================
  // bus decode
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 9;
  localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : timer3_pkg

// File: tick_gen.sv
// prescaler: system clock divided by twelve, and the external oscillator
// divided by eight after a two-flop synchroniser.
// assumes the external oscillator runs below half the system clock.
`timescale 1ns/1ps

module tick_gen
  import timer3_pkg::*;
#(
  parameter int SYS_DIV = SYSTEM_CLOCK_DIV,
  parameter int X_DIV = EXT_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous oscillator pin
  input wire logic ext_osc,
  // one-cycle ticks
  output logic div12_tick,
  output logic ext_tick
);

  localparam int PW = $clog2(SYS_DIV);
  localparam int XW = $clog2(X_DIV);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [PW-1:0] pre;
    logic [XW-1:0] xcnt;
    logic div_tk;
    logic ext_tk;
  } tick_state_t;

  tick_state_t s;
  tick_state_t next_s;

  // ==========================================================
  // next state; sync1 feeds only sync2
  always_comb begin
    next_s = s;
    next_s.sync1 = ext_osc;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.div_tk = 1'b0;
    next_s.ext_tk = 1'b0;
    if (s.pre == PW'(SYS_DIV - 1)) begin
      next_s.pre = '0;
      next_s.div_tk = 1'b1;
    end else begin
      next_s.pre = s.pre + 1'b1;
    end
    // count synchronised rising edges of the oscillator [RULE_08]
    if (s.sync2 && !s.prev) begin
      if (s.xcnt == XW'(X_DIV - 1)) begin
        next_s.xcnt = '0;
        next_s.ext_tk = 1'b1;
      end else begin
        next_s.xcnt = s.xcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign div12_tick = s.div_tk;
  assign ext_tick = s.ext_tk;

endmodule : tick_gen

// File: edge_sync.sv
// two-flop synchroniser with a registered rising-edge pulse.
// assumes the input stays high at least one clock so it is seen.
`timescale 1ns/1ps

module edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous level in
  input wire logic async_in,
  // one-cycle pulse on each rising edge
  output logic rise
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pulse;
  } edge_state_t;

  edge_state_t s;
  edge_state_t next_s;

  // ==========================================================
  // edge detect looks only at the second and third flops
  always_comb begin
    next_s.sync1 = async_in;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.pulse = s.sync2 & ~s.prev;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.pulse;

endmodule : edge_sync

// File: reload_capture_timer.sv
// sixteen-bit reload/capture timer with an AHB-Lite register slave.
// assumes a single master, word transfers only, and that the frame-start
// and low-frequency oscillator inputs come from outside this clock domain.
`timescale 1ns/1ps

module reload_capture_timer
  import timer3_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // event and clock sources
  input wire logic sof_event,
  input wire logic low_frequency_oscillator,
  input wire logic ext_osc,
  // interrupt request level
  output logic timer_irq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [CLOCK_SELECT_WIDTH-1:0] cksel;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic irq;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;

  // ==========================================================
  // helpers

  // per-byte source: system clock, else div12 or ext/8
  function automatic logic tick_pick(input logic sel, input logic xclk,
                                     input logic d12, input logic x8);
    tick_pick = sel ? 1'b1 : (xclk ? x8 : d12);
  endfunction : tick_pick

  // register read mux; unmapped reads as zero
  function automatic logic [7:0] read_mux(input timer_state_t st, input logic [7:0] idx);
    logic [7:0] v;
    v = '0;
    if (idx == IDX_CONTROL) begin
      v = st.ctrl;
    end else if (idx == IDX_RELOAD_LOW) begin
      v = st.reload_low_byte;
    end else if (idx == IDX_RELOAD_HIGH) begin
      v = st.reload_high_byte;
    end else if (idx == IDX_COUNT_LOW) begin
      v = st.count_low_byte;
    end else if (idx == IDX_COUNT_HIGH) begin
      v = st.count_high_byte;
    end else if (idx == IDX_CLOCK_SELECT) begin
      v = {{(8 - CLOCK_SELECT_WIDTH){1'b0}}, st.cksel};
    end
    read_mux = v;
  endfunction : read_mux

  // ==========================================================
  // tick and event sources
  logic div12_tick;
  logic ext_tick;
  logic sof_rise;
  logic slow_osc_rise;

  tick_gen i_tick_gen (
    .clk(clk),
    .nrst(nrst),
    .ext_osc(ext_osc),
    .div12_tick(div12_tick),
    .ext_tick(ext_tick)
  );

  edge_sync i_edge_sync_sof (
    .clk(clk),
    .nrst(nrst),
    .async_in(sof_event),
    .rise(sof_rise)
  );

  edge_sync i_edge_sync_slow_osc (
    .clk(clk),
    .nrst(nrst),
    .async_in(low_frequency_oscillator),
    .rise(slow_osc_rise)
  );

  // ==========================================================
  // counting, capture and register update
  logic split;
  logic capture;
  logic run;
  logic tick_l;
  logic tick_h;
  logic adv_l;
  logic adv_h;
  logic low_roll;
  logic high_roll;
  logic cap_ev;
  logic wr_ctrl;
  logic wr_count;
  logic wr_reload;
  logic take;

  always_comb begin
    next_s = s;
    split = s.ctrl[BIT_SPLIT];
    capture = s.ctrl[BIT_CAPTURE_EN];
    run = s.ctrl[BIT_RUN];
    tick_l = tick_pick(s.cksel[BIT_LOW_CLK_SEL], s.ctrl[BIT_EXT_CLK],
                       div12_tick, ext_tick); // [RULE_07]
    tick_h = tick_pick(s.cksel[BIT_HIGH_CLK_SEL], s.ctrl[BIT_EXT_CLK],
                       div12_tick, ext_tick); // [RULE_07]
    // low byte free-runs in split mode [RULE_05] [RULE_06]
    adv_l = tick_l & (split | run);
    low_roll = adv_l & (s.count_low_byte == BYTE_MAX);
    if (split) begin
      adv_h = tick_h & run; // [RULE_04] [RULE_05] [RULE_15]
      high_roll = adv_h & (s.count_high_byte == BYTE_MAX);
    end else begin
      adv_h = low_roll; // carry from low byte [RULE_01] [RULE_14]
      high_roll = low_roll & (s.count_high_byte == BYTE_MAX);
    end
    // reload only outside capture; capture wraps to zero [RULE_02] [RULE_04] [RULE_20]
    if (adv_l) begin
      if (low_roll && !capture && (split || high_roll)) begin
        next_s.count_low_byte = s.reload_low_byte;
      end else begin
        next_s.count_low_byte = s.count_low_byte + 1'b1;
      end
    end
    if (adv_h) begin
      if (high_roll && !capture) begin
        next_s.count_high_byte = s.reload_high_byte;
      end else begin
        next_s.count_high_byte = s.count_high_byte + 1'b1;
      end
    end
    // capture copies the live count [RULE_13] [RULE_14] [RULE_15] [RULE_18]
    cap_ev = capture & (s.ctrl[BIT_CAP_SRC] ? slow_osc_rise : sof_rise);
    if (cap_ev) begin
      next_s.reload_low_byte = s.count_low_byte;
      next_s.reload_high_byte = s.count_high_byte;
    end
    // data phase write; count write beats counting, capture beats reload write
    wr_ctrl = s.wr_pend & (s.wr_idx == IDX_CONTROL);
    wr_count = s.wr_pend & ((s.wr_idx == IDX_COUNT_LOW) | (s.wr_idx == IDX_COUNT_HIGH));
    wr_reload = s.wr_pend & ((s.wr_idx == IDX_RELOAD_LOW) | (s.wr_idx == IDX_RELOAD_HIGH));
    if (s.wr_pend) begin
      if (s.wr_idx == IDX_CONTROL) begin
        next_s.ctrl = hwdata[7:0]; // [RULE_17]
      end else if (s.wr_idx == IDX_CLOCK_SELECT) begin
        next_s.cksel = hwdata[CLOCK_SELECT_WIDTH-1:0];
      end else if (s.wr_idx == IDX_RELOAD_LOW && !cap_ev) begin
        next_s.reload_low_byte = hwdata[7:0]; // [RULE_18]
      end else if (s.wr_idx == IDX_RELOAD_HIGH && !cap_ev) begin
        next_s.reload_high_byte = hwdata[7:0]; // [RULE_18]
      end else if (s.wr_idx == IDX_COUNT_LOW) begin
        next_s.count_low_byte = hwdata[7:0];
      end else if (s.wr_idx == IDX_COUNT_HIGH) begin
        next_s.count_high_byte = hwdata[7:0];
      end
    end
    // hardware only sets flags; a set beats a same-cycle clear [RULE_09] [RULE_11]
    next_s.ctrl[BIT_HIGH_FLAG] = next_s.ctrl[BIT_HIGH_FLAG] | high_roll | cap_ev;
    next_s.ctrl[BIT_LOW_FLAG] = next_s.ctrl[BIT_LOW_FLAG] | low_roll;
    // interrupt level from the updated flags [RULE_03] [RULE_10] [RULE_14] [RULE_15]
    next_s.irq = next_s.cksel[BIT_TIMER_IRQ_EN] &
                 (next_s.ctrl[BIT_HIGH_FLAG] |
                  (next_s.ctrl[BIT_LOW_IRQ_EN] & next_s.ctrl[BIT_LOW_FLAG]));
    // address phase; read data taken from the updated state [RULE_19]
    take = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
    next_s.wr_pend = take & hwrite;
    next_s.wr_idx = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
    if (take && !hwrite) begin
      next_s.rdata = {24'h000000, read_mux(next_s, haddr[ADDR_IDX_MSB:ADDR_IDX_LSB])};
    end
  end

  // reset clears every register, control included [RULE_17]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign timer_irq = s.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_full_reload;
    !split && !capture && high_roll && !wr_count
      |=> {s.count_high_byte, s.count_low_byte} == $past({s.reload_high_byte, s.reload_low_byte});
  endproperty
  a_full_reload: assert property (p_full_reload) else $error("16-bit reload missed"); // [RULE_02]

  property p_high_flag_on_roll;
    high_roll |=> s.ctrl[BIT_HIGH_FLAG];
  endproperty
  a_high_flag_on_roll: assert property (p_high_flag_on_roll) else $error("high flag not set"); // [RULE_02]

  property p_low_flag;
    low_roll |=> s.ctrl[BIT_LOW_FLAG];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not set on low rollover"); // [RULE_09]

  property p_flags_sticky;
    (s.ctrl[BIT_LOW_FLAG] && s.ctrl[BIT_HIGH_FLAG] && !wr_ctrl) |=>
      (s.ctrl[BIT_LOW_FLAG] && s.ctrl[BIT_HIGH_FLAG]);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("flag cleared by hardware"); // [RULE_11]

  property p_low_free_in_split;
    split && !run && tick_l && s.count_low_byte != BYTE_MAX && !wr_count
      |=> s.count_low_byte == $past(s.count_low_byte) + 8'h01;
  endproperty
  a_low_free_in_split: assert property (p_low_free_in_split) else $error("low byte stalled"); // [RULE_05]

  property p_stopped;
    !split && !run && !wr_count
      |=> $stable({s.count_high_byte, s.count_low_byte});
  endproperty
  a_stopped: assert property (p_stopped) else $error("timer moved while stopped"); // [RULE_06]

  // no write in either cycle, so mode and run bit stay put across the window
  property p_clock_rate;
    !split && run && s.cksel[BIT_LOW_CLK_SEL] && !s.wr_pend && s.count_low_byte != BYTE_MAX
      ##1 !s.wr_pend && s.count_low_byte != BYTE_MAX
      |=> s.count_low_byte == $past(s.count_low_byte, 2) + 8'h02;
  endproperty
  a_clock_rate: assert property (p_clock_rate) else $error("clock rate wrong"); // [RULE_07]

  property p_capture_copy;
    cap_ev |=> {s.reload_high_byte, s.reload_low_byte}
               == $past({s.count_high_byte, s.count_low_byte});
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture did not copy count"); // [RULE_14]

  property p_capture_wrap;
    capture && !split && high_roll && !wr_count
      |=> {s.count_high_byte, s.count_low_byte} == 16'h0000;
  endproperty
  a_capture_wrap: assert property (p_capture_wrap) else $error("capture mode reloaded"); // [RULE_20]

  property p_irq_level;
    s.cksel[BIT_TIMER_IRQ_EN] && (s.ctrl[BIT_HIGH_FLAG] ||
      (s.ctrl[BIT_LOW_IRQ_EN] && s.ctrl[BIT_LOW_FLAG])) |-> timer_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised"); // [RULE_10]

  property p_split_rl_low;
    split && !capture && low_roll && !wr_count
      |=> s.count_low_byte == $past(s.reload_low_byte);
  endproperty
  a_split_rl_low: assert property (p_split_rl_low) else $error("low reload lost"); // [RULE_04]

  property p_split_rl_high;
    split && !capture && high_roll && !wr_count
      |=> s.count_high_byte == $past(s.reload_high_byte);
  endproperty
  a_split_rl_high: assert property (p_split_rl_high) else $error("high reload lost"); // [RULE_04]

  property p_high_halt;
    split && !run && !wr_count
      |=> $stable(s.count_high_byte);
  endproperty
  a_high_halt: assert property (p_high_halt) else $error("high byte ran"); // [RULE_05]

  property p_cap_wrap_low;
    capture && split && low_roll && !wr_count
      |=> s.count_low_byte == 8'h00;
  endproperty
  a_cap_wrap_low: assert property (p_cap_wrap_low) else $error("low reloaded"); // [RULE_15]

  property p_reload_write;
    wr_reload && !cap_ev && s.wr_idx == IDX_RELOAD_LOW
      |=> s.reload_low_byte == $past(hwdata[7:0]);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload write lost"); // [RULE_18]

  property p_ctrl_write;
    wr_ctrl |=> s.ctrl[BIT_LOW_IRQ_EN:BIT_EXT_CLK]
                == $past(hwdata[BIT_LOW_IRQ_EN:BIT_EXT_CLK]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // [RULE_17]

  property p_ctrl_hold;
    !wr_ctrl |=> $stable(s.ctrl[BIT_LOW_IRQ_EN:BIT_EXT_CLK]);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control bit moved"); // [RULE_17]

  property p_irq_on_high;
    s.cksel[BIT_TIMER_IRQ_EN] && !s.wr_pend && high_roll |=> timer_irq;
  endproperty
  a_irq_on_high: assert property (p_irq_on_high) else $error("no high interrupt"); // [RULE_03]

  property p_irq_on_low;
    s.cksel[BIT_TIMER_IRQ_EN] && s.ctrl[BIT_LOW_IRQ_EN] && !s.wr_pend && low_roll |=> timer_irq;
  endproperty
  a_irq_on_low: assert property (p_irq_on_low) else $error("no low interrupt"); // [RULE_10]

  property p_irq_quiet;
    !s.ctrl[BIT_LOW_IRQ_EN] && !s.ctrl[BIT_HIGH_FLAG] && !s.wr_pend && !high_roll && !cap_ev
      |=> !timer_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("stray interrupt"); // [RULE_03]

  property p_cap_irq;
    cap_ev && s.cksel[BIT_TIMER_IRQ_EN] && !s.wr_pend |=> timer_irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("no capture interrupt"); // [RULE_14]

  property p_cap_source;
    capture && !s.ctrl[BIT_CAP_SRC] && slow_osc_rise && !sof_rise && !s.wr_pend
      |=> $stable({s.reload_high_byte, s.reload_low_byte});
  endproperty
  a_cap_source: assert property (p_cap_source) else $error("wrong capture source"); // [RULE_13]

endmodule : reload_capture_timer

// File: event_source.sv
// far-side model: frame-start detector, slow oscillator and external oscillator.
// assumes the bench calls pulse right after a rising edge of clk.
`timescale 1ns/1ps

module event_source (
  // clock
  input wire logic clk,
  // external oscillator enable from the bench
  input wire logic ext_on,
  // event and clock outputs
  output logic sof_event,
  output logic low_frequency_oscillator,
  output logic ext_osc
);
  // ==========================================================
  // idle levels
  initial begin
    sof_event = 1'h0;
    low_frequency_oscillator = 1'h0;
    ext_osc = 1'h0;
  end

  // odd half period keeps the oscillator unrelated in phase to clk
  always #83 ext_osc <= ext_on ? ~ext_osc : 1'h0;

  // ==========================================================
  // one event: four clocks high so the synchroniser cannot miss it
  task automatic pulse(input logic from_slow_osc);
    if (from_slow_osc) begin
      low_frequency_oscillator <= 1'h1;
    end else begin
      sof_event <= 1'h1;
    end
    repeat (4) @(posedge clk);
    sof_event <= 1'h0;
    low_frequency_oscillator <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : pulse
endmodule : event_source

// File: tb_reload_capture_timer.sv
// self-checking bench for the reload/capture timer over its AHB-Lite port.
// assumes zero-wait slave; event_source stands in for the event sources.
`timescale 1ns/1ps

module tb_reload_capture_timer
  import timer3_pkg::*;
;
  logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, timer_irq, ext_on;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sof_event, low_frequency_oscillator, ext_osc;
  logic [7:0] v;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  // ==========================================================
  // design and far side
  assign hready = hreadyout;
  reload_capture_timer i_reload_capture_timer (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sof_event(sof_event), .low_frequency_oscillator(low_frequency_oscillator),
    .ext_osc(ext_osc), .timer_irq(timer_irq));
  event_source i_event_source (.clk(clk), .ext_on(ext_on), .sof_event(sof_event),
    .low_frequency_oscillator(low_frequency_oscillator), .ext_osc(ext_osc));

  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // hang guard: whole run needs about fifteen hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  // ==========================================================
  // bus cycles: enter and leave just after a rising edge
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel <= 1'h1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    ck("hresp", 8'h00, {7'h00, hresp});
    rd = hrdata[7:0];
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(idx, 1'h1, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    bus(idx, 1'h0, 8'h00, d);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // ==========================================================
  // comparisons
  task automatic ck(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : ck

  task automatic ckr(input string what, input logic [7:0] lo, input logic [7:0] hi,
                     input logic [7:0] got);
    compares++;
    if (^got === 1'hX || got < lo || got > hi) begin
      bad_count++;
      $display("wrong value %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : ckr

  task automatic ck_irq(input logic exp);
    ck("timer_irq", {7'h00, exp}, {7'h00, timer_irq});
  endtask : ck_irq

  // ==========================================================
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd(IDX_CONTROL + 8'(i), v);
      ck("reset value", 8'h00, v);
    end
    wr(8'h97, 8'h5A);
    rd(8'h97, v);
    ck("unmapped", 8'h00, v);
    wr(IDX_CONTROL, 8'hE3);
    rd(IDX_CONTROL, v);
    ck("control rw", 8'hE3, v);
    wr(IDX_RELOAD_LOW, 8'h55);
    wr(IDX_RELOAD_HIGH, 8'hAA);
    rd(IDX_RELOAD_LOW, v);
    ck("reload low rw", 8'h55, v);
    rd(IDX_RELOAD_HIGH, v);
    ck("reload high rw", 8'hAA, v);
    wr(IDX_CONTROL, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_reload16;
    wr(IDX_CLOCK_SELECT, 8'h07);
    wr(IDX_RELOAD_HIGH, 8'h12);
    wr(IDX_RELOAD_LOW, 8'h34);
    wr(IDX_COUNT_HIGH, 8'hFF);
    wr(IDX_COUNT_LOW, 8'hF0);
    idle(10);
    rd(IDX_COUNT_LOW, v);
    ck("stopped count", 8'hF0, v);
    wr(IDX_CONTROL, 8'h04);
    idle(40);
    rd(IDX_CONTROL, v);
    ck("flags on wrap", 8'hC4, v);
    ck_irq(1'h1);
    rd(IDX_COUNT_HIGH, v);
    ck("reloaded high", 8'h12, v);
    idle(40);
    rd(IDX_CONTROL, v);
    ck("flags kept", 8'hC4, v);
    wr(IDX_CONTROL, 8'h04);
    rd(IDX_CONTROL, v);
    ck("flags cleared", 8'h04, v);
    // low byte passes 0xFF with its interrupt left off, as software should
    idle(150);
    rd(IDX_CONTROL, v);
    ck("low flag 16-bit", 8'h44, v);
    ck_irq(1'h0);
    wr(IDX_CONTROL, 8'h64);
    idle(2);
    ck_irq(1'h1);
    wr(IDX_CONTROL, 8'h00);
    $display("test reload16 done");
  endtask : t_reload16

  task automatic t_split;
    wr(IDX_COUNT_HIGH, 8'h77);
    wr(IDX_RELOAD_LOW, 8'hA0);
    wr(IDX_COUNT_LOW, 8'hF8);
    wr(IDX_CONTROL, 8'h08);
    idle(30);
    rd(IDX_CONTROL, v);
    ck("split low flag", 8'h48, v);
    ck_irq(1'h0);
    rd(IDX_COUNT_LOW, v);
    ckr("split low reload", 8'hA0, 8'hC8, v);
    rd(IDX_COUNT_HIGH, v);
    ck("high held", 8'h77, v);
    wr(IDX_CONTROL, 8'h28);
    idle(110);
    rd(IDX_CONTROL, v);
    ck("low irq flags", 8'h68, v);
    ck_irq(1'h1);
    wr(IDX_RELOAD_HIGH, 8'h40);
    wr(IDX_COUNT_HIGH, 8'hFC);
    wr(IDX_CONTROL, 8'h0C);
    idle(20);
    rd(IDX_CONTROL, v);
    ck("high flag", 8'h80, v & 8'h80);
    ck_irq(1'h1);
    rd(IDX_COUNT_HIGH, v);
    ck("high reload", 8'h53, v);
    wr(IDX_CONTROL, 8'h00);
    $display("test split done");
  endtask : t_split

  task automatic t_clocks;
    ext_on <= 1'h1;
    wr(IDX_CLOCK_SELECT, 8'h04);
    wr(IDX_COUNT_HIGH, 8'h00);
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_CONTROL, 8'h04);
    idle(120);
    rd(IDX_COUNT_LOW, v);
    ckr("div12 count", 8'h09, 8'h0B, v);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_CONTROL, 8'h05);
    idle(700);
    rd(IDX_COUNT_LOW, v);
    ckr("ext div8 count", 8'h08, 8'h0B, v);
    wr(IDX_CONTROL, 8'h00);
    ext_on <= 1'h0;
    $display("test clocks done");
  endtask : t_clocks

  task automatic t_capture;
    wr(IDX_CLOCK_SELECT, 8'h07);
    wr(IDX_COUNT_HIGH, 8'hAB);
    wr(IDX_COUNT_LOW, 8'hCD);
    wr(IDX_CONTROL, 8'h10);
    i_event_source.pulse(1'h0);
    rd(IDX_RELOAD_LOW, v);
    ck("capture low", 8'hCD, v);
    rd(IDX_RELOAD_HIGH, v);
    ck("capture high", 8'hAB, v);
    ck_irq(1'h1);
    wr(IDX_COUNT_LOW, 8'h33);
    i_event_source.pulse(1'h1);
    rd(IDX_RELOAD_LOW, v);
    ck("slow osc ignored", 8'hCD, v);
    wr(IDX_CONTROL, 8'h12);
    wr(IDX_COUNT_HIGH, 8'h11);
    wr(IDX_COUNT_LOW, 8'h22);
    i_event_source.pulse(1'h0);
    rd(IDX_RELOAD_LOW, v);
    ck("frame ignored", 8'hCD, v);
    i_event_source.pulse(1'h1);
    rd(IDX_RELOAD_LOW, v);
    ck("slow osc capture", 8'h22, v);
    wr(IDX_COUNT_HIGH, 8'hFF);
    wr(IDX_COUNT_LOW, 8'hF8);
    wr(IDX_CONTROL, 8'h14);
    idle(30);
    rd(IDX_COUNT_HIGH, v);
    ck("free wrap", 8'h00, v);
    wr(IDX_CONTROL, 8'h1A);
    wr(IDX_COUNT_HIGH, 8'h5A);
    wr(IDX_COUNT_LOW, 8'hFC);
    i_event_source.pulse(1'h1);
    rd(IDX_RELOAD_HIGH, v);
    ck("split capture", 8'h5A, v);
    ck_irq(1'h1);
    wr(IDX_CONTROL, 8'h00);
    $display("test capture done");
  endtask : t_capture

  // ==========================================================
  // verdict
  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    nrst = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_on = 1'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_reset;
    t_reload16;
    t_split;
    t_clocks;
    t_capture;
    tally_and_finish;
  end
endmodule : tb_reload_capture_timer
